// [addr_map_pkg.sv]
// Constants and address decoding shared by both ends of the paged register link.
package addr_map_pkg;

  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int SPI_ADDR_W = 7;
  localparam int MAP_DEPTH = 256;

  localparam logic [7:0] STATUS_ADDR = 8'h73;
  localparam int PAGE_BIT = 4;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;

  // Frame: one read flag bit, the address bits, then one data byte, MSB first.
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] I2C_FRAME_LAST = 5'h10;
  localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
  localparam logic [4:0] I2C_ADDR_LAST = 5'h08;

  localparam int REF_CLK_HZ = 50_000_000;
  localparam int SCLK_MAX_HZ = 10_000_000;
  // Least half period of the link clock, rounded up to whole reference cycles.
  localparam int SCLK_HALF_CYC = (REF_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);

  // Full map address from the transmitted address bits.
  function automatic logic [7:0] map_addr(input logic i2c, input logic page,
                                          input logic [7:0] a);
    logic [7:0] r;
    r = a;
    if (!i2c) begin
      if (a[6:0] == STATUS_ADDR[6:0]) begin
        r = STATUS_ADDR;
      end else begin
        r = {~page, a[6:0]};
      end
    end
    return r;
  endfunction : map_addr

  // Page value the SPI page bit must hold for a full map address.
  function automatic logic page_for(input logic [7:0] a);
    return ~a[7];
  endfunction : page_for

endpackage : addr_map_pkg

// [reg_link_chk.sv]
// Timing and framing checks on the serial register link between host and sensor ends.
module reg_link_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic i2c_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sclk_q;
  logic next_sclk_q;
  logic [4:0] bits;
  logic [4:0] next_bits;

  // Rising link clock edges are counted per frame so the frame length can be judged at its end.
  always_comb begin
    next_sclk_q = sclk;
    next_bits = cs_n ? 5'h00 : bits + {4'h0, sclk & ~sclk_q};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      bits <= 5'h00;
    end else begin
      sclk_q <= next_sclk_q;
      bits <= next_bits;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // The bench runs the host with a half period of two reference cycles.
  sequence lead_low;
    !sclk [*2];
  endsequence

  spi_frame_a: assert property ($rose(cs_n) && !$past(i2c_sel) |-> bits == 5'h10)
    else $error("SPI frame did not carry sixteen bits");
  i2c_frame_a: assert property ($rose(cs_n) && $past(i2c_sel) |-> bits == 5'h11)
    else $error("I2C frame did not carry seventeen bits");
  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("Link clock moved outside a frame");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("Host data changed while the link clock was high");
  miso_hold_a: assert property (!cs_n && $past(!cs_n) && !sclk && $past(!sclk)
    |-> $stable(miso))
    else $error("Device data changed while the link clock was low");
  sel_stable_a: assert property (!cs_n && $past(!cs_n) |-> $stable(i2c_sel))
    else $error("Addressing mode changed inside a frame");
  frame_start_a: assert property ($fell(cs_n) |-> lead_low)
    else $error("Link clock rose too early in a frame");
  frame_time_a: assert property ($fell(cs_n) |-> ##[1:80] $rose(cs_n))
    else $error("Frame did not end in time");
endmodule : reg_link_chk

// [reg_link_if.sv]
// Serial register link between the host end and the sensor end.
interface reg_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic i2c_sel;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    input i2c_sel,
    output miso
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    output i2c_sel,
    input miso
  );
endinterface : reg_link_if

// [sensor_regs_dev.sv]
// Sensor end: paged 8-bit register map reached over the serial link.

// How it works
// - Every location holds and moves eight bits.
// - I2C sends full 8-bit address, page ignored.
// - SPI frame carries only seven address bits.
// - SPI address joins page bit for location.
// - Page bit resets zero, selecting upper half.
// - Page bit one routes SPI to lower half.
// - Host avoids reserved writes, trusts no reads.
// - Page bit is status bit 4, both pages.
module sensor_regs_dev
  import addr_map_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  reg_link_if.dev link,
  output logic page_o,
  output logic wr_stb_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [REG_W-1:0] wr_data_o
);

  // Frame state lives on the link clock and is cleared by the select line.
  // The link clock stops between frames, so no edge after the last bit is
  // needed to return to the start of a frame.
  logic frame_rst;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic rd_flag;
  logic next_rd_flag;
  logic [7:0] addr_sh;
  logic [7:0] next_addr_sh;
  logic [ADDR_W-1:0] full_addr;
  logic [ADDR_W-1:0] next_full_addr;
  logic [REG_W-1:0] rx_sh;
  logic [REG_W-1:0] next_rx_sh;
  logic [REG_W-1:0] tx_sh;
  logic [REG_W-1:0] next_tx_sh;

  // Register storage and write notification, reset only by rst_i.
  logic [REG_W-1:0] mem [MAP_DEPTH];
  logic [REG_W-1:0] next_mem [MAP_DEPTH];
  logic wr_tgl;
  logic next_wr_tgl;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [ADDR_W-1:0] next_wr_addr_q;
  logic [REG_W-1:0] wr_data_q;
  logic [REG_W-1:0] next_wr_data_q;

  logic page;
  logic [4:0] addr_last;
  logic [4:0] frame_last;
  logic [7:0] addr_full_bits;
  logic [ADDR_W-1:0] decoded;
  logic commit;

  assign frame_rst = rst_i | link.cs_n;
  assign page = mem[STATUS_ADDR][PAGE_BIT];
  assign link.miso = tx_sh[REG_W-1];

  always_comb begin
    if (link.i2c_sel) begin
      addr_last = I2C_ADDR_LAST;
      frame_last = I2C_FRAME_LAST;
    end else begin
      addr_last = SPI_ADDR_LAST;
      frame_last = SPI_FRAME_LAST;
    end
  end

  assign addr_full_bits = {addr_sh[6:0], link.mosi};
  // The page is sampled only when the address completes, so a page write
  // inside this frame lands after the decode and steers the next one.
  assign decoded = map_addr(link.i2c_sel, page, addr_full_bits);
  assign commit = !rd_flag && (bit_cnt == frame_last);

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_rd_flag = rd_flag;
    next_addr_sh = addr_sh;
    next_full_addr = full_addr;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    if (bit_cnt != 5'h1f) begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
    if (bit_cnt == 5'h00) begin
      next_rd_flag = link.mosi;
    end else if (bit_cnt <= addr_last) begin
      next_addr_sh = addr_full_bits;
      if (bit_cnt == addr_last) begin
        next_full_addr = decoded;
        next_tx_sh = mem[decoded];
      end
    end else if (bit_cnt <= frame_last) begin
      next_rx_sh = {rx_sh[REG_W-2:0], link.mosi};
      next_tx_sh = {tx_sh[REG_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= 5'h00;
      rd_flag <= 1'b0;
      addr_sh <= 8'h00;
      full_addr <= 8'h00;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      rd_flag <= next_rd_flag;
      addr_sh <= next_addr_sh;
      full_addr <= next_full_addr;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
    end
  end

  // Reserved locations are plain storage; the host is trusted to leave them.
  always_comb begin
    next_mem = mem;
    next_wr_tgl = wr_tgl;
    next_wr_addr_q = wr_addr_q;
    next_wr_data_q = wr_data_q;
    if (commit) begin
      next_mem[full_addr] = {rx_sh[REG_W-2:0], link.mosi};
      next_wr_tgl = ~wr_tgl;
      next_wr_addr_q = full_addr;
      next_wr_data_q = {rx_sh[REG_W-2:0], link.mosi};
    end
  end

  always_ff @(posedge link.sclk or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < MAP_DEPTH; i++) begin
        mem[i] <= MEM_RST;
      end
      mem[STATUS_ADDR] <= STATUS_RST;
      wr_tgl <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      mem <= next_mem;
      wr_tgl <= next_wr_tgl;
      wr_addr_q <= next_wr_addr_q;
      wr_data_q <= next_wr_data_q;
    end
  end

  // Reference clock side: page level and write events cross by synchronisers.
  // Address and data of a write are held for a whole frame after the toggle,
  // which is far longer than the synchroniser delay, so they are safe to take.
  logic [2:0] page_s;
  logic [2:0] next_page_s;
  logic [2:0] tgl_s;
  logic [2:0] next_tgl_s;
  logic tgl_seen;
  logic next_tgl_seen;
  logic next_page_o;
  logic next_wr_stb_o;
  logic [ADDR_W-1:0] next_wr_addr_o;
  logic [REG_W-1:0] next_wr_data_o;

  always_comb begin
    next_page_s = {page_s[1:0], page};
    next_tgl_s = {tgl_s[1:0], wr_tgl};
    next_tgl_seen = tgl_seen;
    next_page_o = page_o;
    next_wr_stb_o = 1'b0;
    next_wr_addr_o = wr_addr_o;
    next_wr_data_o = wr_data_o;
    if (page_s[1] == page_s[2]) begin
      next_page_o = page_s[2];
    end
    if ((tgl_s[1] == tgl_s[2]) && (tgl_s[2] != tgl_seen)) begin
      next_tgl_seen = tgl_s[2];
      next_wr_stb_o = 1'b1;
      next_wr_addr_o = wr_addr_q;
      next_wr_data_o = wr_data_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_s <= 3'h0;
      tgl_s <= 3'h0;
      tgl_seen <= 1'b0;
      page_o <= 1'b0;
      wr_stb_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else begin
      page_s <= next_page_s;
      tgl_s <= next_tgl_s;
      tgl_seen <= next_tgl_seen;
      page_o <= next_page_o;
      wr_stb_o <= next_wr_stb_o;
      wr_addr_o <= next_wr_addr_o;
      wr_data_o <= next_wr_data_o;
    end
  end

endmodule : sensor_regs_dev

// [sensor_regs_host.sv]
// Host end: turns register requests into link frames, switching page as needed.
module sensor_regs_host
  import addr_map_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
)(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  reg_link_if.host link,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_i2c_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [REG_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [REG_W-1:0] rdata_o,
  output logic page_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b11,
    ST_TAIL = 2'b10
  } host_state_t;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  host_state_t state, next_state;
  logic [7:0] div, next_div;
  logic [4:0] bit_idx, next_bit_idx;
  logic [4:0] last_idx, next_last_idx;
  logic [16:0] tx_sh, next_tx_sh;
  logic [REG_W-1:0] rx_sh, next_rx_sh;
  logic pend, next_pend;
  logic page_frame, next_page_frame;
  logic q_write, next_q_write;
  logic q_i2c, next_q_i2c;
  logic [ADDR_W-1:0] q_addr, next_q_addr;
  logic [REG_W-1:0] q_wdata, next_q_wdata;
  logic next_sclk, next_cs_n, next_mosi, next_i2c_sel;
  logic sclk_q, cs_n_q, mosi_q, i2c_sel_q;
  logic next_ready, next_done, next_page;
  logic [REG_W-1:0] next_rdata;

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
  assign link.i2c_sel = i2c_sel_q;

  // Left-aligned frame: read flag, address, data.
  function automatic logic [16:0] build(input logic i2c, input logic wr,
                                        input logic [7:0] a, input logic [7:0] d);
    logic [16:0] f;
    f = {~wr, a[6:0], d, 1'b0};
    if (i2c) begin
      f = {~wr, a, d};
    end
    return f;
  endfunction : build

  always_comb begin
    next_state = state;
    next_div = div;
    next_bit_idx = bit_idx;
    next_last_idx = last_idx;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_pend = pend;
    next_page_frame = page_frame;
    next_q_write = q_write;
    next_q_i2c = q_i2c;
    next_q_addr = q_addr;
    next_q_wdata = q_wdata;
    next_sclk = sclk_q;
    next_cs_n = cs_n_q;
    next_mosi = mosi_q;
    next_i2c_sel = i2c_sel_q;
    next_done = 1'b0;
    next_page = page_o;
    next_rdata = rdata_o;
    unique case (state)
      ST_IDLE: begin
        // A request counts only while ready stands, so the first edge after
        // reset, where ready is still low, cannot start a frame.
        if (pend || (req_valid_i && req_ready_o)) begin
          if (!pend) begin
            next_q_write = req_write_i;
            next_q_i2c = req_i2c_i;
            next_q_addr = req_addr_i;
            next_q_wdata = req_wdata_i;
          end
          next_state = ST_LOW;
          next_div = 8'h00;
          next_bit_idx = 5'h00;
          next_cs_n = 1'b0;
          next_sclk = 1'b0;
          next_i2c_sel = pend ? q_i2c : req_i2c_i;
          next_last_idx = next_i2c_sel ? I2C_FRAME_LAST : SPI_FRAME_LAST;
          next_page_frame = 1'b0;
          next_pend = 1'b0;
          if (!pend && !req_i2c_i && (req_addr_i[6:0] != STATUS_ADDR[6:0]) &&
              (page_for(req_addr_i) != page_o)) begin
            // Switch the page first; the request follows in the next frame.
            next_page_frame = 1'b1;
            next_pend = 1'b1;
            next_page = page_for(req_addr_i);
            next_tx_sh = build(1'b0, 1'b1, STATUS_ADDR,
                               8'(next_page) << PAGE_BIT);
          end else begin
            next_tx_sh = pend ? build(q_i2c, q_write, q_addr, q_wdata)
                              : build(req_i2c_i, req_write_i, req_addr_i, req_wdata_i);
            if (!pend && req_write_i && (req_i2c_i ? (req_addr_i == STATUS_ADDR)
                : (req_addr_i[6:0] == STATUS_ADDR[6:0]))) begin
              // A user write to the status byte moves the page too, so track it here.
              next_page = req_wdata_i[PAGE_BIT];
            end
          end
          next_mosi = next_tx_sh[16];
        end
      end
      ST_LOW: begin
        next_div = div + 8'h01;
        if (div == HALF_LAST) begin
          next_div = 8'h00;
          next_sclk = 1'b1;
          next_rx_sh = {rx_sh[REG_W-2:0], link.miso};
          next_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        next_div = div + 8'h01;
        if (div == HALF_LAST) begin
          next_div = 8'h00;
          next_sclk = 1'b0;
          if (bit_idx == last_idx) begin
            next_state = ST_TAIL;
          end else begin
            next_bit_idx = bit_idx + 5'h01;
            next_tx_sh = {tx_sh[15:0], 1'b0};
            next_mosi = tx_sh[15];
            next_state = ST_LOW;
          end
        end
      end
      ST_TAIL: begin
        next_div = div + 8'h01;
        if (div == HALF_LAST) begin
          next_div = 8'h00;
          next_cs_n = 1'b1;
          next_mosi = 1'b0;
          next_state = ST_IDLE;
          if (!page_frame) begin
            next_done = 1'b1;
            if (!q_write) begin
              next_rdata = rx_sh;
            end
          end
        end
      end
    endcase
    next_ready = (next_state == ST_IDLE) && !next_pend;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      div <= 8'h00;
      bit_idx <= 5'h00;
      last_idx <= 5'h00;
      tx_sh <= 17'h00000;
      rx_sh <= 8'h00;
      pend <= 1'b0;
      page_frame <= 1'b0;
      q_write <= 1'b0;
      q_i2c <= 1'b0;
      q_addr <= 8'h00;
      q_wdata <= 8'h00;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      i2c_sel_q <= 1'b0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      page_o <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      bit_idx <= next_bit_idx;
      last_idx <= next_last_idx;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      pend <= next_pend;
      page_frame <= next_page_frame;
      q_write <= next_q_write;
      q_i2c <= next_q_i2c;
      q_addr <= next_q_addr;
      q_wdata <= next_q_wdata;
      sclk_q <= next_sclk;
      cs_n_q <= next_cs_n;
      mosi_q <= next_mosi;
      i2c_sel_q <= next_i2c_sel;
      req_ready_o <= next_ready;
      done_o <= next_done;
      rdata_o <= next_rdata;
      page_o <= next_page;
    end
  end

endmodule : sensor_regs_host

// [testbench.sv]
// Self-checking bench joining the host end to the sensor end over the register link.
module testbench
  import addr_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_i, rst_i, req_valid_i, req_write_i, req_i2c_i;
  logic [7:0] req_addr_i, req_wdata_i, rdata_o, wr_addr_o, wr_data_o;
  logic req_ready_o, done_o, page_h, page_d, wr_stb_o, pg;
  int err_total, tests_run, n;
  logic [15:0] wq[$];
  // Row: i2c, write, address, write data, expected read data.
  logic [25:0] rows [13] = '{
    {2'b01, 8'h85, 8'h3c, 8'h00}, {2'b00, 8'h85, 8'h00, 8'h3c},
    {2'b01, 8'h05, 8'ha5, 8'h00}, {2'b00, 8'h05, 8'h00, 8'ha5},
    {2'b00, 8'h85, 8'h00, 8'h3c}, {2'b11, 8'h05, 8'h5a, 8'h00},
    {2'b10, 8'h85, 8'h00, 8'h3c}, {2'b00, 8'h73, 8'h00, 8'h00},
    {2'b01, 8'h7f, 8'hff, 8'h00}, {2'b00, 8'h73, 8'h00, 8'h10},
    {2'b00, 8'h80, 8'h00, 8'h00}, {2'b10, 8'h05, 8'h00, 8'h5a},
    {2'b10, 8'h73, 8'h00, 8'h00}};

  reg_link_if link();
  sensor_regs_host #(.HALF_CYC(2)) u_sensor_regs_host (.ref_clk_i, .rst_i, .link(link),
    .req_valid_i, .req_write_i, .req_i2c_i, .req_addr_i, .req_wdata_i, .req_ready_o,
    .done_o, .rdata_o, .page_o(page_h));
  sensor_regs_dev u_sensor_regs_dev (.ref_clk_i, .rst_i, .link(link), .page_o(page_d),
    .wr_stb_o, .wr_addr_o, .wr_data_o);
  reg_link_chk u_reg_link_chk (.ref_clk_i, .rst_i, .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso), .i2c_sel(link.i2c_sel));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) begin
    if (wr_stb_o === 1'b1) wq.push_back({wr_addr_o, wr_data_o});
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic bound(input int lim);
    if (n >= lim) begin
      chk("timeout", 16'h0001, 16'h0000);
      end_sim();
    end
  endtask : bound

  // A page frame is expected ahead of an SPI access, other than to STATUS_ADDR, whose half differs from the current page.
  task automatic access(input logic i2c, input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input logic [7:0] e);
    logic sw;
    sw = !i2c && a != STATUS_ADDR && ~a[7] != pg;
    @(negedge ref_clk_i);
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_i2c_i = i2c;
    req_addr_i = a;
    req_wdata_i = d;
    for (n = 0; req_ready_o !== 1'b1 && n < 400; n++) @(negedge ref_clk_i);
    bound(400);
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    for (n = 0; done_o !== 1'b1 && n < 400; n++) @(negedge ref_clk_i);
    bound(400);
    if (!wr) chk("read data", {8'h00, rdata_o}, {8'h00, e});
    for (n = 0; wq.size() < 16'(sw) + 16'(wr) && n < 20; n++) @(negedge ref_clk_i);
    repeat (8) @(negedge ref_clk_i);
    chk("write count", 16'(wq.size()), 16'(sw) + 16'(wr));
    if (sw) begin
      pg = ~a[7];
      chk("page write", wq[0], {STATUS_ADDR, 3'h0, pg, 4'h0});
    end
    if (wr) chk("write", wq[wq.size()-1], {a, d});
    if (wr && a == STATUS_ADDR) pg = d[PAGE_BIT];
    chk("page", {14'h0, page_h, page_d}, {14'h0, pg, pg});
    wq.delete();
  endtask : access

  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_i2c_i = 1'b0;
    req_addr_i = 8'h00;
    req_wdata_i = 8'h00;
    err_total = 0;
    tests_run = 0;
    pg = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    chk("reset page", {14'h0, page_h, page_d}, 16'h0000);
    for (int i = 0; i < 13; i++) begin
      access(rows[i][25], rows[i][24], rows[i][23:16], rows[i][15:8], rows[i][7:0]);
      $display("row %0d done", i);
    end
    // A direct status write moves the page, and the next access follows it.
    access(1'b0, 1'b1, STATUS_ADDR, 8'h10, 8'h00);
    access(1'b0, 1'b0, 8'h05, 8'h00, 8'h5a);
    $display("status write test done");
    // A reset in mid-run must return the page to zero and clear the map.
    access(1'b0, 1'b1, 8'h10, 8'h11, 8'h00);
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    rst_i = 1'b0;
    pg = 1'b0;
    @(negedge ref_clk_i);
    chk("page after reset", {14'h0, page_h, page_d}, 16'h0000);
    access(1'b0, 1'b0, 8'h10, 8'h00, 8'h00);
    $display("reset test done");
    end_sim();
  end
endmodule : testbench
